// *** verilog/eeh_host.sv ***
// Host controller driving a paged byte-wide EEPROM over its parallel pins
// Overview of operation
// R1: Reads keep select and output drive low, write strobe high, then sample data.
// R2: Device floats data whenever select or output drive is high; host never contends.
// R3: Writes pulse the strobe low with select low and output drive high.
// R4: Address is set before the strobe falls and held through the pulse.
// R5: Data is driven before and held past the strobe's rising edge.
// R6: Device times programming itself; host only waits for completion.
// R7: A page load carries one to thirty-two bytes.
// R8: Further bytes go only well inside the 150 us load window.
// R9: Every byte of one page load keeps the same page select bits.
// R10: Low five address bits pick the byte; any order, rewrites allowed.
// R11: Device programs only loaded bytes of the page.
// R12: Polling reads the last byte until the poll bit shows true data.
// R13: Polling also waits until the toggle bit stops changing.
// R14: Device blocks writes below its supply sense threshold.
// R15: No write is issued within 5 ms of start-up.
// R16: Strobe never falls while output drive low or select high.
// R17: Write pulses last far longer than 15 ns.
// R18: Erase holds select low, output drive at high voltage, 10 ms strobe pulse.
// R19: Identification bytes use the high-voltage address line and 1FE0H-1FFFH.
// R20: No new access is made until programming completion is seen; on poll timeout the host raises wr_timeout and returns to idle without it.
`timescale 1ns/1ps
`default_nettype none
module eeh_host #(
  parameter int unsigned BLC_CYC = eeh_pkg::BLC_CYC,
  parameter int unsigned ERASE_CYC = eeh_pkg::ERASE_CYC,
  parameter int unsigned PWRUP_CYC = eeh_pkg::PWRUP_CYC,
  parameter int unsigned WC_CYC = eeh_pkg::WC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eeh_pkg::eeh_op_type cmd_op,
  input wire logic cmd_id,
  input wire logic cmd_last,
  input wire logic [eeh_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [eeh_pkg::DATA_W-1:0] cmd_data,
  // User answers
  output logic rsp_valid,
  output logic [eeh_pkg::DATA_W-1:0] rsp_data,
  output logic wr_done,
  output logic wr_timeout,
  output logic busy,
  // Memory pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic oe_hv,
  output logic id_area_hv_address_line,
  output logic [eeh_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [eeh_pkg::DATA_W-1:0] dq_i,
  output logic [eeh_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe
);
  localparam int TW = eeh_pkg::TW;
  localparam int AW = eeh_pkg::ADDR_W;
  localparam int DW = eeh_pkg::DATA_W;
  localparam int PL = eeh_pkg::PAGE_LSB;
  localparam int CW = eeh_pkg::CNT_W;

  if (BLC_CYC <= eeh_pkg::LOAD_GUARD || ERASE_CYC < 8 || PWRUP_CYC < 1 || WC_CYC < 1 ||
      ERASE_CYC >= (64'd1 << TW) || PWRUP_CYC >= (64'd1 << TW) || WC_CYC >= (64'd1 << TW)) begin : g_chk
    $error("eeh_host: timing parameters out of range");
  end

  typedef enum {
    ST_PWRUP, ST_IDLE, ST_RD_ACC, ST_RD_FLOAT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
    ST_LOAD, ST_POLL_ACC, ST_POLL_GAP, ST_ER_SETUP, ST_ER_PULSE, ST_ER_HOLD
  } eeh_state_type;

  eeh_state_type state_r, st_nxt;
  logic ce_n_r, ce_nxt, oe_n_r, oe_nxt, we_n_r, we_nxt, oe_hv_r, hv_nxt, a9_r, a9_nxt;
  logic [AW-1:0] addr_r, addr_nxt, last_addr_r, last_addr_nxt, cur_addr_r, cur_addr_nxt;
  logic [DW-1:0] dq_o_r, dq_o_nxt, last_data_r, last_data_nxt, cur_data_r, cur_data_nxt;
  logic [DW-1:0] rsp_data_r, rsp_data_nxt;
  logic dq_oe_r, dq_oe_nxt, ready_r, ready_nxt, rsp_valid_r, rsp_valid_nxt;
  logic done_r, done_nxt, tmo_r, tmo_nxt, busy_r, busy_nxt;
  logic pend_r, pend_nxt, close_r, close_nxt, polled_r, polled_nxt, ok_r, ok_nxt;
  logic prev_b6_r, prev_b6_nxt, cur_id_r, cur_id_nxt, cur_last_r, cur_last_nxt;
  eeh_pkg::eeh_op_type cur_op_r, cur_op_nxt;
  logic [eeh_pkg::PAGE_W-1:0] page_r, page_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic ph_load, win_load;
  logic [TW-1:0] ph_val, win_val, ph_cnt, win_cnt;
  logic [AW-1:0] eff_addr;

  // Phase timer paces pin edges; window timer covers power-up, load window and poll timeout
  eeh_timer #(.W(TW), .RST_VAL(0)) u_phase (
    .clk(clk), .srst(srst), .load(ph_load), .load_val(ph_val), .count(ph_cnt));
  eeh_timer #(.W(TW), .RST_VAL(PWRUP_CYC)) u_window (
    .clk(clk), .srst(srst), .load(win_load), .load_val(win_val), .count(win_cnt));

  // Identification accesses land in the top page
  assign eff_addr = cur_id_r ? {eeh_pkg::ID_PAGE, cur_addr_r[PL-1:0]} : cur_addr_r; // R19

  // Sequencer next state
  always_comb begin
    st_nxt = state_r; ce_nxt = ce_n_r; oe_nxt = oe_n_r; we_nxt = we_n_r; hv_nxt = oe_hv_r;
    a9_nxt = a9_r; addr_nxt = addr_r; dq_o_nxt = dq_o_r; dq_oe_nxt = dq_oe_r;
    last_addr_nxt = last_addr_r; last_data_nxt = last_data_r; rsp_data_nxt = rsp_data_r;
    cur_addr_nxt = cur_addr_r; cur_data_nxt = cur_data_r; cur_op_nxt = cur_op_r;
    cur_id_nxt = cur_id_r; cur_last_nxt = cur_last_r; pend_nxt = pend_r; close_nxt = close_r;
    polled_nxt = polled_r; ok_nxt = ok_r; prev_b6_nxt = prev_b6_r; page_nxt = page_r;
    cnt_nxt = cnt_r; rsp_valid_nxt = 1'b0; done_nxt = 1'b0; tmo_nxt = 1'b0;
    ph_load = 1'b0; ph_val = '0; win_load = 1'b0; win_val = '0;
    // Commands are latched on the handshake and dispatched from the latch
    if (cmd_valid && ready_r) begin
      pend_nxt = 1'b1; cur_op_nxt = cmd_op; cur_id_nxt = cmd_id; cur_last_nxt = cmd_last;
      cur_addr_nxt = cmd_addr; cur_data_nxt = cmd_data;
    end
    case (state_r)
      ST_PWRUP: begin
        if (win_cnt == '0) st_nxt = ST_IDLE; // R15
      end
      ST_IDLE: begin
        if (pend_r) begin
          pend_nxt = 1'b0; a9_nxt = cur_id_r; addr_nxt = eff_addr; ce_nxt = 1'b0;
          case (cur_op_r)
            eeh_pkg::OP_WRITE: begin
              dq_o_nxt = cur_data_r; dq_oe_nxt = 1'b1; cnt_nxt = '0; // R5
              page_nxt = eff_addr[AW-1:PL]; close_nxt = 1'b0; st_nxt = ST_WR_SETUP; // R9
            end
            eeh_pkg::OP_ERASE: begin
              a9_nxt = 1'b0; hv_nxt = 1'b1; ph_load = 1'b1; // R18
              ph_val = TW'(eeh_pkg::EHS_CYC); st_nxt = ST_ER_SETUP;
            end
            default: begin
              oe_nxt = 1'b0; ph_load = 1'b1; ph_val = TW'(eeh_pkg::ACC_CYC); st_nxt = ST_RD_ACC; // R1
            end
          endcase
        end
      end
      ST_RD_ACC: begin
        if (ph_cnt == '0) begin
          rsp_data_nxt = dq_i; rsp_valid_nxt = 1'b1; ce_nxt = 1'b1; oe_nxt = 1'b1; // R1
          ph_load = 1'b1; ph_val = TW'(eeh_pkg::DF_CYC); st_nxt = ST_RD_FLOAT; // R2
        end
      end
      ST_RD_FLOAT: begin
        if (ph_cnt == '0) begin
          a9_nxt = 1'b0; st_nxt = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        // Address stood a full cycle before the strobe falls
        we_nxt = 1'b0; ph_load = 1'b1; ph_val = TW'(eeh_pkg::WP_CYC); st_nxt = ST_WR_PULSE; // R3 R4
      end
      ST_WR_PULSE: begin
        if (ph_cnt == '0) begin
          we_nxt = 1'b1; ph_load = 1'b1; ph_val = TW'(eeh_pkg::AH_CYC); st_nxt = ST_WR_HOLD; // R17
        end
      end
      ST_WR_HOLD: begin
        if (ph_cnt == '0) begin
          ce_nxt = 1'b1; dq_oe_nxt = 1'b0; last_addr_nxt = addr_r; last_data_nxt = dq_o_r; // R5
          cnt_nxt = cnt_r + CW'(1); win_load = 1'b1; win_val = TW'(BLC_CYC); // R8
          close_nxt = cur_last_r || (cnt_r + CW'(1) == CW'(eeh_pkg::PAGE_BYTES)); // R7
          st_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (pend_r && !close_r && cur_op_r == eeh_pkg::OP_WRITE && cur_id_r == a9_r &&
            eff_addr[AW-1:PL] == page_r && win_cnt > TW'(eeh_pkg::LOAD_GUARD)) begin // R8 R9 R10
          pend_nxt = 1'b0; addr_nxt = eff_addr; dq_o_nxt = cur_data_r; dq_oe_nxt = 1'b1;
          ce_nxt = 1'b0; st_nxt = ST_WR_SETUP;
        end else begin
          // Any other pending command closes the page; either way wait for the window to lapse
          if (pend_r) close_nxt = 1'b1;
          if (win_cnt == '0) begin
            close_nxt = 1'b0; polled_nxt = 1'b0; ok_nxt = 1'b0; addr_nxt = last_addr_r;
            win_load = 1'b1; win_val = TW'(WC_CYC); ce_nxt = 1'b0; oe_nxt = 1'b0; // R6
            ph_load = 1'b1; ph_val = TW'(eeh_pkg::ACC_CYC); st_nxt = ST_POLL_ACC;
          end
        end
      end
      ST_POLL_ACC: begin
        if (ph_cnt == '0) begin
          prev_b6_nxt = dq_i[eeh_pkg::TOGGLE_BIT]; polled_nxt = 1'b1;
          ok_nxt = polled_r && (dq_i[eeh_pkg::POLL_BIT] == last_data_r[eeh_pkg::POLL_BIT]) && // R12
                   (dq_i[eeh_pkg::TOGGLE_BIT] == prev_b6_r); // R13
          ce_nxt = 1'b1; oe_nxt = 1'b1; ph_load = 1'b1; ph_val = TW'(eeh_pkg::DF_CYC);
          st_nxt = ST_POLL_GAP;
        end
      end
      ST_POLL_GAP: begin
        if (ph_cnt == '0) begin
          if (ok_r) begin
            done_nxt = 1'b1; a9_nxt = 1'b0; st_nxt = ST_IDLE; // R20
          end else if (win_cnt == '0) begin
            tmo_nxt = 1'b1; a9_nxt = 1'b0; st_nxt = ST_IDLE;
          end else begin
            ce_nxt = 1'b0; oe_nxt = 1'b0; ph_load = 1'b1; ph_val = TW'(eeh_pkg::ACC_CYC);
            st_nxt = ST_POLL_ACC;
          end
        end
      end
      ST_ER_SETUP: begin
        if (ph_cnt == '0) begin
          we_nxt = 1'b0; ph_load = 1'b1; ph_val = TW'(ERASE_CYC); st_nxt = ST_ER_PULSE; // R18
        end
      end
      ST_ER_PULSE: begin
        if (ph_cnt == '0) begin
          we_nxt = 1'b1; ph_load = 1'b1; ph_val = TW'(eeh_pkg::EHS_CYC); st_nxt = ST_ER_HOLD;
        end
      end
      ST_ER_HOLD: begin
        if (ph_cnt == '0) begin
          ce_nxt = 1'b1; hv_nxt = 1'b0; done_nxt = 1'b1; st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // Ready only where a new command can be latched
    ready_nxt = !pend_nxt && (st_nxt == ST_IDLE || (st_nxt == ST_LOAD && !close_nxt));
    busy_nxt = pend_nxt || st_nxt != ST_IDLE;
  end

  // Sequencer registers; pins idle deselected and undriven
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_PWRUP; ce_n_r <= 1'b1; oe_n_r <= 1'b1; we_n_r <= 1'b1; oe_hv_r <= 1'b0;
      a9_r <= 1'b0; addr_r <= '0; dq_o_r <= '0; dq_oe_r <= 1'b0; last_addr_r <= '0;
      last_data_r <= '0; rsp_data_r <= '0; cur_addr_r <= '0; cur_data_r <= '0;
      cur_op_r <= eeh_pkg::OP_READ; cur_id_r <= 1'b0; cur_last_r <= 1'b0; pend_r <= 1'b0;
      close_r <= 1'b0; polled_r <= 1'b0; ok_r <= 1'b0; prev_b6_r <= 1'b0; page_r <= '0;
      cnt_r <= '0; ready_r <= 1'b0; rsp_valid_r <= 1'b0; done_r <= 1'b0; tmo_r <= 1'b0;
      busy_r <= 1'b1;
    end else begin
      state_r <= st_nxt; ce_n_r <= ce_nxt; oe_n_r <= oe_nxt; we_n_r <= we_nxt; oe_hv_r <= hv_nxt;
      a9_r <= a9_nxt; addr_r <= addr_nxt; dq_o_r <= dq_o_nxt; dq_oe_r <= dq_oe_nxt;
      last_addr_r <= last_addr_nxt; last_data_r <= last_data_nxt; rsp_data_r <= rsp_data_nxt;
      cur_addr_r <= cur_addr_nxt; cur_data_r <= cur_data_nxt; cur_op_r <= cur_op_nxt;
      cur_id_r <= cur_id_nxt; cur_last_r <= cur_last_nxt; pend_r <= pend_nxt;
      close_r <= close_nxt; polled_r <= polled_nxt; ok_r <= ok_nxt; prev_b6_r <= prev_b6_nxt;
      page_r <= page_nxt; cnt_r <= cnt_nxt; ready_r <= ready_nxt; rsp_valid_r <= rsp_valid_nxt;
      done_r <= done_nxt; tmo_r <= tmo_nxt; busy_r <= busy_nxt;
    end
  end

  // Every output is a flop
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign wr_done = done_r;
  assign wr_timeout = tmo_r;
  assign busy = busy_r;
  assign ce_n = ce_n_r;
  assign oe_n = oe_n_r;
  assign we_n = we_n_r;
  assign oe_hv = oe_hv_r;
  assign id_area_hv_address_line = a9_r;
  assign mem_addr = addr_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

  // Checks on the pin sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_strobe_fall;
    $fell(we_n_r) && !oe_hv_r;
  endsequence
  sequence s_pulse_held;
    (!we_n_r && !ce_n_r && $stable(addr_r) && $stable(dq_o_r))[*8];
  endsequence
  sequence s_erase_fall;
    $fell(we_n_r) && oe_hv_r;
  endsequence

  strobe_gating_a: assert property (!we_n_r |-> (!ce_n_r && oe_n_r)) // R16
    else $error("strobe low without select or with output drive");
  pulse_width_a: assert property (s_strobe_fall |-> s_pulse_held) // R17
    else $error("write pulse too short or pins moved");
  data_hold_a: assert property ($rose(we_n_r) && !oe_hv_r |-> dq_oe_r && $stable(dq_o_r) ##1 dq_oe_r) // R5
    else $error("data released at strobe rise");
  no_contention_a: assert property (!oe_n_r |-> !dq_oe_r) // R2
    else $error("host drives data while output drive low");
  same_page_a: assert property ($fell(we_n_r) && !oe_hv_r |-> addr_r[AW-1:PL] == page_r) // R9
    else $error("page bits changed within a load");
  page_count_a: assert property (cnt_r <= CW'(eeh_pkg::PAGE_BYTES)) // R7
    else $error("more than a page of bytes loaded");
  // Follow-on strobe must fall with margin left, two cycles after the window test
  window_margin_a: assert property ($fell(we_n_r) && !oe_hv_r && cnt_r != '0 |-> win_cnt >= TW'(eeh_pkg::LOAD_GUARD - 1)) // R8
    else $error("byte loaded too late in the window");
  powerup_quiet_a: assert property (state_r == ST_PWRUP |-> we_n_r && ce_n_r) // R15
    else $error("access during power-up delay");
  erase_pulse_a: assert property (s_erase_fall |-> (!we_n_r && !ce_n_r && oe_hv_r)[*8]) // R18
    else $error("erase pulse not held at high voltage");
  id_page_a: assert property (a9_r && !ce_n_r |-> addr_r[AW-1:PL] == eeh_pkg::ID_PAGE) // R19
    else $error("identification access outside top page");
  poll_before_done_a: assert property ($rose(done_r) && !$past(oe_hv_r) |-> $past(ok_r)) // R20
    else $error("write done reported without completion seen");
endmodule // eeh_host
`default_nettype wire

// *** verilog/eeh_pkg.sv ***
// Constants shared by the paged EEPROM host controller
`default_nettype none
package eeh_pkg;
  // Bus geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_W = ADDR_W - PAGE_LSB;
  localparam int PAGE_BYTES = 32;
  localparam int CNT_W = 6;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [PAGE_W-1:0] ID_PAGE = 8'hFF;
  // Timer width, enough for the longest count
  localparam int TW = 20;
  // Clock and printed times
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 100;
  localparam int T_AH_NS = 50;
  localparam int T_ACC_NS = 150;
  localparam int T_DF_NS = 50;
  localparam int T_EHS_US = 1;
  localparam int T_BLC_US = 150;
  localparam int T_ERASE_MS = 10;
  localparam int T_PWRUP_MS = 5;
  localparam int T_WC_MS = 2;
  // Least times and waits round up, only the load window rounds down
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int DF_CYC = (T_DF_NS + CLK_NS - 1) / CLK_NS;
  localparam int EHS_CYC = (T_EHS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BLC_CYC = (T_BLC_US * 1000) / CLK_NS;
  localparam int ERASE_CYC = (T_ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = (T_PWRUP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC = (T_WC_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  // Margin left in the load window before another byte is risked
  localparam int LOAD_GUARD = 64;
  // Commands on the user port
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_ERASE
  } eeh_op_type;
endpackage
`default_nettype wire

// *** verilog/eeh_timer.sv ***
// Loadable down counter used for phase and window timing
`timescale 1ns/1ps
`default_nettype none
module eeh_timer #(
  parameter int unsigned W = 20,
  parameter int unsigned RST_VAL = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Load request
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Remaining cycles
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  if (RST_VAL >= (64'd1 << W)) begin : g_chk
    $error("eeh_timer: reset value does not fit");
  end

  // Count down to zero and rest there
  always_comb begin
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= W'(RST_VAL);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
endmodule // eeh_timer
`default_nettype wire

// *** sim/eeh_mem_model.sv ***
// Behavioural paged EEPROM as seen from the host controller's pins
`timescale 1ns/1ps
`default_nettype none
module eeh_mem_model #(
  parameter int BLC_NS = 2000,
  parameter int WC_NS = 3000,
  parameter int ERASE_NS = 500,
  parameter int PWR_NS = 200,
  parameter int GLITCH_NS = 15
) (
  // Strobes and high-voltage lines
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic oe_hv,
  input wire logic a9_hv,
  // Address and data
  input wire logic [eeh_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  output logic [7:0] dq_i,
  // Host faults seen
  output int bad_cnt
);
  logic [7:0] mem [0:8191];
  logic [7:0] idm [0:31];
  logic [7:0] pg_dat [0:31];
  logic [31:0] pg_set = '0;
  logic [12:0] a_lat, last_a;
  logic [7:0] last_d, pg_page;
  logic [7:0] last_rd = 8'h00;
  logic a9_lat, pg_id;
  logic wr_on = 1'b0;
  logic loading = 1'b0;
  logic prog = 1'b0;
  logic tgl = 1'b0;
  time t_fall, t_last;
  wire logic rd_en = !ce_n && !oe_n && we_n;

  function automatic logic [7:0] rd_byte(input logic [12:0] a, input logic id);
    return id ? idm[a[4:0]] : mem[a];
  endfunction

  // Known pattern so that untouched bytes stand out
  initial begin
    bad_cnt = 0;
    for (int k = 0; k < 8192; k++) mem[k] = k[7:0] ^ 8'h5A;
    for (int k = 0; k < 32; k++) idm[k] = k[7:0] ^ 8'hC3;
  end

  // Released line shows the inverse of the last byte, never a lucky match
  always_comb begin
    dq_i = dq_oe ? dq_o : ~last_rd;
    if (rd_en) begin
      dq_i = rd_byte(addr, a9_hv);
      if (prog && addr == last_a) dq_i[7] = ~last_d[7];
      if (prog) dq_i[6] = tgl;
    end
  end

  // Each read while busy flips the toggle bit; polls must aim at the last byte
  always @(posedge rd_en) begin
    if (prog) tgl = ~tgl;
    if (prog && addr != last_a) bad_cnt++;
    last_rd = rd_byte(addr, a9_hv);
  end

  // Address latches on the later falling strobe, only with output drive high
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n && (oe_n || oe_hv)) begin
      a_lat = addr;
      a9_lat = a9_hv;
      t_fall = $time;
      wr_on = 1'b1;
    end else if (!we_n && !ce_n) bad_cnt++;
  end

  // Data latches on the first rising strobe; short or early pulses are dropped
  always @(posedge we_n or posedge ce_n) begin
    if (wr_on) begin
      wr_on = 1'b0;
      if (oe_hv && $time - t_fall >= ERASE_NS) begin
        for (int k = 0; k < 8192; k++) mem[k] = 8'hFF;
      end else if (!oe_hv && $time - t_fall >= GLITCH_NS && $time >= PWR_NS) begin
        if (prog) bad_cnt++;
        else begin
          if (loading && (a_lat[12:5] != pg_page || a9_lat != pg_id)) bad_cnt++;
          pg_page = a_lat[12:5];
          pg_id = a9_lat;
          pg_dat[a_lat[4:0]] = dq_o;
          pg_set[a_lat[4:0]] = 1'b1;
          last_a = a_lat;
          last_d = dq_o;
          t_last = $time;
          loading = 1'b1;
        end
      end
    end
  end

  // Window lapse starts self-timed programming of the loaded bytes only
  always begin
    #10;
    if (loading && $time - t_last >= BLC_NS) begin
      loading = 1'b0;
      prog = 1'b1;
      #(WC_NS);
      for (int k = 0; k < 32; k++) begin
        if (pg_set[k] && pg_id) idm[k] = pg_dat[k];
        else if (pg_set[k]) mem[{pg_page, k[4:0]}] = pg_dat[k];
      end
      pg_set = '0;
      prog = 1'b0;
    end
  end
endmodule // eeh_mem_model
`default_nettype wire

// *** sim/eeh_host_test.sv ***
// Self-checking bench for the paged EEPROM host controller
`timescale 1ns/1ps
`default_nettype none
module eeh_host_test;
  localparam int BLC = 200;
  localparam int NS = eeh_pkg::CLK_NS;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  eeh_pkg::eeh_op_type cmd_op = eeh_pkg::OP_READ;
  logic cmd_id = 1'b0;
  logic cmd_last = 1'b0;
  logic [12:0] cmd_addr = 13'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, wr_done, wr_timeout, busy;
  logic ce_n, oe_n, we_n, oe_hv, a9_hv, dq_oe;
  logic [12:0] mem_addr;
  logic [7:0] rsp_data, dq_i, dq_o;
  int bad_cnt;
  int fail_count = 0;
  int n_compared = 0;

  eeh_host #(.BLC_CYC(BLC), .ERASE_CYC(50), .PWRUP_CYC(20), .WC_CYC(2000)) i_dut (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_id(cmd_id), .cmd_last(cmd_last), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .wr_done(wr_done), .wr_timeout(wr_timeout),
    .busy(busy), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .oe_hv(oe_hv),
    .id_area_hv_address_line(a9_hv), .mem_addr(mem_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  eeh_mem_model #(.BLC_NS(BLC * NS), .WC_NS(300 * NS), .ERASE_NS(50 * NS), .PWR_NS(20 * NS)) i_mem (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .oe_hv(oe_hv), .a9_hv(a9_hv), .addr(mem_addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .bad_cnt(bad_cnt));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait: a read answer, or a write completion or give-up pulse
  task automatic wait_for(input bit want_done);
    int n;
    n = 0;
    // Sampled at the falling edge, half a cycle after the pulse was launched
    do begin
      @(negedge clk);
      n++;
    end while ((want_done ? (wr_done | wr_timeout) : rsp_valid) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      check("wait", 8'h01, 8'h00);
      give_verdict();
    end
  endtask

  // Offer one command and hold it until the edge that takes it
  task automatic send(input eeh_pkg::eeh_op_type op, input logic id, input logic last,
                      input logic [12:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_id = id;
    cmd_last = last;
    cmd_addr = a;
    cmd_data = d;
    n = 0;
    // Ready seen at a falling edge means the next rising edge takes the command
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) begin
      check("cmd_ready", 8'h01, 8'h00);
      give_verdict();
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic rd(input logic id, input logic [12:0] a, input logic [7:0] exp);
    send(eeh_pkg::OP_READ, id, 1'b0, a, 8'h00);
    wait_for(1'b1 == 1'b0);
    check("rsp_data", exp, rsp_data);
  endtask

  task automatic done();
    wait_for(1'b1);
    check("wr_done", 8'h01, {6'h00, wr_timeout, wr_done});
  endtask

  // Lone byte with poll bit set, neighbour untouched
  task automatic t_byte();
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b1, 13'h0123, 8'hA5);
    done();
    check("busy", 8'h00, {7'h00, busy});
    rd(1'b0, 13'h0123, 8'hA5);
    rd(1'b0, 13'h0124, 8'h24 ^ 8'h5A);
  endtask

  // Out-of-order page load with an overwrite
  task automatic t_page();
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h081F, 8'h11);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0800, 8'h80);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0805, 8'h7F);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0800, 8'h22);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b1, 13'h0810, 8'h6E);
    done();
    rd(1'b0, 13'h081F, 8'h11);
    rd(1'b0, 13'h0800, 8'h22);
    rd(1'b0, 13'h0805, 8'h7F);
    rd(1'b0, 13'h0810, 8'h6E);
    rd(1'b0, 13'h0801, 8'h01 ^ 8'h5A);
  endtask

  // Full 32-byte page in one programming period
  task automatic t_full();
    for (int k = 0; k < 32; k++) send(eeh_pkg::OP_WRITE, 1'b0, k == 31, 13'h1000 | k[12:0], k[7:0] ^ 8'h96);
    done();
    for (int k = 0; k < 32; k++) rd(1'b0, 13'h1000 | k[12:0], k[7:0] ^ 8'h96);
    rd(1'b0, 13'h1020, 8'h20 ^ 8'h5A);
  endtask

  // No closing byte: the load window lapses by itself
  task automatic t_lapse();
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0201, 8'h3C);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0202, 8'hC3);
    done();
    rd(1'b0, 13'h0201, 8'h3C);
    rd(1'b0, 13'h0202, 8'hC3);
  endtask

  // Bytes of two pages: the second is held until the first has programmed
  task automatic t_cross();
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b0, 13'h0300, 8'h55);
    send(eeh_pkg::OP_WRITE, 1'b0, 1'b1, 13'h0320, 8'hAA);
    done();
    done();
    rd(1'b0, 13'h0300, 8'h55);
    rd(1'b0, 13'h0320, 8'hAA);
    rd(1'b0, 13'h0301, 8'h01 ^ 8'h5A);
  endtask

  // Identification bytes beside the main array
  task automatic t_id();
    send(eeh_pkg::OP_WRITE, 1'b1, 1'b1, 13'h1FE5, 8'h3E);
    done();
    rd(1'b1, 13'h1FE5, 8'h3E);
    rd(1'b0, 13'h1FE5, 8'hE5 ^ 8'h5A);
  endtask

  // Chip clear leaves every byte high
  task automatic t_erase();
    send(eeh_pkg::OP_ERASE, 1'b0, 1'b0, 13'h0000, 8'h00);
    done();
    rd(1'b0, 13'h0123, 8'hFF);
    rd(1'b0, 13'h1FFF, 8'hFF);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    check("pins in reset", 8'hE1, {ce_n, oe_n, we_n, dq_oe, oe_hv, a9_hv, cmd_ready, busy});
    srst = 1'b0;
    repeat (10) @(negedge clk);
    check("cmd_ready in power-up", 8'h00, {7'h00, cmd_ready});
    t_byte();
    t_page();
    t_full();
    t_lapse();
    t_cross();
    t_id();
    t_erase();
    // Saturate so that a multiple of 256 faults cannot read as zero
    check("host pin faults", 8'h00, 8'(bad_cnt > 255 ? 255 : bad_cnt));
    give_verdict();
  end
endmodule // eeh_host_test
`default_nettype wire
